// *** verilog/tmr0_overflow_counter.sv ***
// Timer/counter zero with prescaler, pin count input and AXI4-Lite slave
// How it works
// - Select code picks stop, clock or divided clock
// - Codes 110/111 count pin falling/rising edges
// - Divided clocks share one 10-bit prescaler
// - Eight-bit up counter, readable and writable
// - After write, counting resumes from written value
// - Count pin synchronised before edge detection
// - Pin edges count even when driven as output
// - Overflow sets flag bit one
// - Flag clears on vector ack or write-one
// - Interrupt when flag, enable and global set
// - Reserved bits always read zero
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module tmr0_overflow_counter
   import tmr0_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        reset,
   // AXI4-Lite write address
   input  wire logic [4:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [4:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Count pin, sampled whatever its port direction
   input  wire logic        extCountPin,
   // Overflow interrupt request and its vector
   output logic             overflowIrq,
   output logic [7:0]       irqVector
);
`include "tmr0_regs.svh"

   // ----------------------------------------------------------------
   // Register map, byte addresses
   // ----------------------------------------------------------------
   // 0x00 count source select in bits 2:0
   // 0x04 counter value
   // 0x08 overflow interrupt enable in bit 1
   // 0x0C overflow flag in bit 1, a written one clears it
   // 0x10 bit 0 global interrupt enable, bit 1 vector taken strobe
   // Every register is one byte in lane zero of its word
   // Other addresses answer a slave error and change nothing

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   // Register state
   logic [2:0]  clkSel;
   logic [7:0]  counterValue;
   logic        overflowIrqEnable;
   logic        overflowFlag;
   logic        globalIrqEnable;

   // Pin and prescaler
   logic [2:0]  pinSync;
   logic        tickDiv8;
   logic        tickDiv64;
   logic        tickDiv256;
   logic        tickDiv1024;
   logic        pinRise;
   logic        pinFall;
   logic        countTick;
   logic        wrapEvent;

   // Bus side
   logic        wrAddrHeld;
   logic        wrDataHeld;
   logic [4:0]  wrAddr;
   logic [31:0] wrData;
   logic [3:0]  wrStrb;
   logic        wrFire;
   logic        wrHit;
   logic        wrSel;
   logic        wrVal;
   logic        wrMask;
   logic        wrFlags;
   logic        wrCpu;
   logic        rdFire;
   logic        rdHit;
   logic [7:0]  rdByte;

   // Next values and strobes
   logic [7:0]  next_counterValue;
   logic        next_overflowFlag;
   logic        flagClear;
   logic        vectorAck;
   logic        next_irq;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // Shared by both channels, so reads and writes agree on the map
   function automatic logic isMapped(input logic [4:0] a);
      isMapped = (a == {1'b0, `TMR0_OFF_CLKSEL}) ||
                 (a == {1'b0, `TMR0_OFF_VALUE})  ||
                 (a == {1'b0, `TMR0_OFF_MASK})   ||
                 (a == {1'b0, `TMR0_OFF_FLAGS})  ||
                 (a == `TMR0_OFF_CPUCTL);
   endfunction

   // ----------------------------------------------------------------
   // Prescaler
   // ----------------------------------------------------------------
   // Runs free from reset and is never cleared by a select change,
   // so the first divided period after a change may be short; the
   // trade is one shared divider instead of one per tap
   tmr0_prescaler uPrescaler (
      .mclk        (mclk),
      .reset       (reset),
      .tickDiv8    (tickDiv8),
      .tickDiv64   (tickDiv64),
      .tickDiv256  (tickDiv256),
      .tickDiv1024 (tickDiv1024)
   );

   // ----------------------------------------------------------------
   // Count pin synchroniser and edge detect
   // ----------------------------------------------------------------
   // Three stages; edges come from stages two and three only.
   // No agreement filter on the level: it would swallow the
   // two-cycle pulses that the pin source is allowed to send
   always_ff @(posedge mclk) begin
      if (reset) begin
         pinSync <= 3'h0;
      end else begin
         pinSync <= {pinSync[1:0], extCountPin};
      end
   end

   // Pin is an input here, so output drive never masks edges
   assign pinRise = pinSync[1] & ~pinSync[2];
   assign pinFall = ~pinSync[1] & pinSync[2];

   // ----------------------------------------------------------------
   // Count source selection
   // ----------------------------------------------------------------
   // Stop only holds the counter; the prescaler keeps running.
   // Pin modes act on synchronised edges, three cycles after the pin
   always_comb begin
      case (tmr0_cs_e'(clkSel))
         TMR0_CS_STOP:    countTick = 1'b0;
         TMR0_CS_CLK:     countTick = 1'b1;
         TMR0_CS_DIV8:    countTick = tickDiv8;
         TMR0_CS_DIV64:   countTick = tickDiv64;
         TMR0_CS_DIV256:  countTick = tickDiv256;
         TMR0_CS_DIV1024: countTick = tickDiv1024;
         TMR0_CS_EXTFALL: countTick = pinFall;
         TMR0_CS_EXTRISE: countTick = pinRise;
         default:         countTick = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // AXI4-Lite write path
   // ----------------------------------------------------------------
   // Address and data are held independently, either may come first.
   // Both beats are taken on one ready pulse, the held pair fires on
   // the next edge and the response rises with the register update.
   // Strobe lane zero gates every write; other lanes hold no bits
   assign wrFire  = wrAddrHeld & wrDataHeld & ~s_axi_bvalid;
   assign wrHit   = wrFire & wrStrb[0] & isMapped(wrAddr);
   assign wrSel   = wrHit & (wrAddr == {1'b0, `TMR0_OFF_CLKSEL});
   assign wrVal   = wrHit & (wrAddr == {1'b0, `TMR0_OFF_VALUE});
   assign wrMask  = wrHit & (wrAddr == {1'b0, `TMR0_OFF_MASK});
   assign wrFlags = wrHit & (wrAddr == {1'b0, `TMR0_OFF_FLAGS});
   assign wrCpu   = wrHit & (wrAddr == `TMR0_OFF_CPUCTL);

   // Beat capture and response; a held beat blocks its ready
   always_ff @(posedge mclk) begin
      if (reset) begin
         wrAddrHeld    <= 1'b0;
         wrDataHeld    <= 1'b0;
         wrAddr        <= 5'h00;
         wrData        <= 32'h0000_0000;
         wrStrb        <= 4'h0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `TMR0_RESP_OKAY;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            wrAddrHeld <= 1'b1;
            wrAddr     <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            wrDataHeld <= 1'b1;
            wrData     <= s_axi_wdata;
            wrStrb     <= s_axi_wstrb;
         end
         if (wrFire) begin
            wrAddrHeld   <= 1'b0;
            wrDataHeld   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= isMapped(wrAddr) ? `TMR0_RESP_OKAY
                                             : `TMR0_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Ready drops while a beat is held, so one write at a time.
   // Pulsing every other idle cycle halves throughput, which the
   // register traffic of a timer never notices
   always_ff @(posedge mclk) begin
      if (reset) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= ~wrAddrHeld & ~s_axi_awready &
                          ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
         s_axi_wready  <= ~wrDataHeld & ~s_axi_wready &
                          ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   // Reserved bits are not stored, so they can never read back set
   always_ff @(posedge mclk) begin
      if (reset) begin
         clkSel            <= 3'h0;
         overflowIrqEnable <= 1'b0;
         globalIrqEnable   <= 1'b0;
      end else begin
         if (wrSel) begin
            clkSel <= wrData[`TMR0_CS_MSB:0];
         end
         if (wrMask) begin
            overflowIrqEnable <= wrData[`TMR0_OVF_BIT];
         end
         if (wrCpu) begin
            globalIrqEnable <= wrData[`TMR0_GIE_BIT];
         end
      end
   end

   // ----------------------------------------------------------------
   // Counter and overflow flag
   // ----------------------------------------------------------------
   // A write wins over a tick in its cycle; the next tick counts on.
   // Limitation: the tick lost to a write is not replayed.
   // Wrap is judged on the value before the tick, so the flag and
   // the step to 00 land on the same edge
   assign wrapEvent = countTick & ~wrVal &
                      (counterValue == `TMR0_CNT_MAX);
   assign next_counterValue = wrVal ? wrData[7:0]
                            : countTick ? counterValue + `TMR0_CNT_ONE
                            : counterValue;

   // Vector ack is a write-only strobe in the cpu control word
   assign vectorAck = wrCpu & wrData[`TMR0_ACK_BIT];
   assign flagClear = (wrFlags & wrData[`TMR0_OVF_BIT]) | vectorAck;
   // Set beats clear so an overflow is never lost
   assign next_overflowFlag = wrapEvent | (overflowFlag & ~flagClear);

   // Counter and flag share one process and so one edge
   always_ff @(posedge mclk) begin
      if (reset) begin
         counterValue <= `TMR0_RST_BYTE;
         overflowFlag <= 1'b0;
      end else begin
         counterValue <= next_counterValue;
         overflowFlag <= next_overflowFlag;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt output
   // ----------------------------------------------------------------
   // Built from the next flag value, so the request rises on the
   // wrap edge itself and drops on the edge that clears the flag;
   // the global enable lives in the cpu control word
   assign next_irq = next_overflowFlag & overflowIrqEnable &
                     globalIrqEnable;

   // Vector shown only while the request stands, zero otherwise
   always_ff @(posedge mclk) begin
      if (reset) begin
         overflowIrq <= 1'b0;
         irqVector   <= `TMR0_RST_BYTE;
      end else begin
         overflowIrq <= next_irq;
         irqVector   <= next_irq ? `TMR0_VECTOR : `TMR0_RST_BYTE;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read path
   // ----------------------------------------------------------------
   // Unused bits are tied low in every read image
   always_comb begin
      case (s_axi_araddr)
         {1'b0, `TMR0_OFF_CLKSEL}: rdByte = {5'h00, clkSel};
         {1'b0, `TMR0_OFF_VALUE}:  rdByte = counterValue;
         {1'b0, `TMR0_OFF_MASK}:   rdByte = {6'h00, overflowIrqEnable, 1'b0};
         {1'b0, `TMR0_OFF_FLAGS}:  rdByte = {6'h00, overflowFlag, 1'b0};
         `TMR0_OFF_CPUCTL:         rdByte = {7'h00, globalIrqEnable};
         default:                  rdByte = `TMR0_RST_BYTE;
      endcase
   end

   // The image is taken from the live address on the handshake edge
   // and held with rvalid, so a stalled master still sees one value
   assign rdFire = s_axi_arvalid & s_axi_arready;
   assign rdHit  = isMapped(s_axi_araddr);

   // Unmapped reads answer a slave error with zero data
   always_ff @(posedge mclk) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `TMR0_RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & ~rdFire;
         if (rdFire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rdByte};
            s_axi_rresp  <= rdHit ? `TMR0_RESP_OKAY : `TMR0_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

// *** verilog/tmr0_regs.svh ***
// Register offsets, field positions and reset values of the timer block
`ifndef TMR0_REGS_SVH
`define TMR0_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TMR0_OFF_CLKSEL  4'h0
`define TMR0_OFF_VALUE   4'h4
`define TMR0_OFF_MASK    4'h8
`define TMR0_OFF_FLAGS   4'hC
`define TMR0_OFF_CPUCTL  5'h10

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define TMR0_OVF_BIT     1
`define TMR0_CS_MSB      2
`define TMR0_GIE_BIT     0
`define TMR0_ACK_BIT     1

// ----------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------
`define TMR0_RST_BYTE    8'h00
`define TMR0_CNT_MAX     8'hFF
`define TMR0_CNT_ONE     8'h01
`define TMR0_PRE_ONE     10'h001
`define TMR0_PRE_RST     10'h000
`define TMR0_VECTOR      8'h03
`define TMR0_RESP_OKAY   2'b00
`define TMR0_RESP_SLVERR 2'b10

`endif

// *** verilog/tmr0_pkg.sv ***
// Types shared by the timer block
package tmr0_pkg;
   // Clock-select codes of the counter
   typedef enum logic [2:0] {
      TMR0_CS_STOP  = 3'b000,
      TMR0_CS_CLK   = 3'b001,
      TMR0_CS_DIV8  = 3'b010,
      TMR0_CS_DIV64 = 3'b011,
      TMR0_CS_DIV256  = 3'b100,
      TMR0_CS_DIV1024 = 3'b101,
      TMR0_CS_EXTFALL = 3'b110,
      TMR0_CS_EXTRISE = 3'b111
   } tmr0_cs_e;
endpackage

// *** verilog/tmr0_prescaler.sv ***
// Shared 10-bit prescaler producing the divided count enables
`timescale 1ns/1ps
module tmr0_prescaler
   import tmr0_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       reset,
   output logic            tickDiv8,
   output logic            tickDiv64,
   output logic            tickDiv256,
   output logic            tickDiv1024
);
`include "tmr0_regs.svh"

   logic [9:0] preCount;
   logic [9:0] next_preCount;

   // ----------------------------------------------------------------
   // Free running divider
   // ----------------------------------------------------------------
   // One counter serves every tap, so taps stay phase locked
   assign next_preCount = preCount + `TMR0_PRE_ONE;

   always_ff @(posedge mclk) begin
      if (reset) begin
         preCount <= `TMR0_PRE_RST;
      end else begin
         preCount <= next_preCount;
      end
   end

   // Taps fire on the cycle the low bits roll over
   assign tickDiv8    = &preCount[2:0];
   assign tickDiv64   = &preCount[5:0];
   assign tickDiv256  = &preCount[7:0];
   assign tickDiv1024 = &preCount[9:0];
endmodule

// *** dv/tmr0_overflow_counter_monitor.sv ***
// Concurrent checks on the bus and interrupt ports of the timer block
`timescale 1ns/1ps
module tmr0_overflow_counter_monitor (
   input wire logic        mclk,
   input wire logic        reset,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [4:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        overflowIrq,
   input wire logic [7:0]  irqVector
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   logic [4:0] rdAddr;
   // Remember the read address, rdata carries no address of its own
   always_ff @(posedge mclk) begin
      if (reset) rdAddr <= 5'h00;
      else if (s_axi_arvalid && s_axi_arready) rdAddr <= s_axi_araddr;
   end
   property p_vec; irqVector == (overflowIrq ? 8'h03 : 8'h00); endproperty
   a_vec: assert property (p_vec) else $error("vector mismatch");
   property p_rsv; s_axi_rvalid && rdAddr == 5'h00 |-> s_axi_rdata[31:3] == 0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("select reserved bits set");
   property p_rsvm; s_axi_rvalid && (rdAddr == 5'h08 || rdAddr == 5'h0C)
      |-> s_axi_rdata[31:2] == 0 && !s_axi_rdata[0]; endproperty
   a_rsvm: assert property (p_rsvm) else $error("irq reserved bits set");
   property p_unmap; s_axi_rvalid && rdAddr > 5'h10
      |-> s_axi_rresp == 2'b10 && s_axi_rdata == 0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rlat: assert property (p_rlat) else $error("read late");
   property p_rhold; s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_rhold: assert property (p_rhold) else $error("read dropped");
   property p_bhold; s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_bhold: assert property (p_bhold) else $error("response dropped");
   property p_wlat; s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
   a_wlat: assert property (p_wlat) else $error("write late");
endmodule
bind tmr0_overflow_counter tmr0_overflow_counter_monitor i_mon (.*);

// *** dv/tmr0_pin_source.sv ***
// Pulse source standing on the external count pin
`timescale 1ns/1ps
module tmr0_pin_source (
   input wire logic mclk,
   output logic     pinLevel
);
   initial pinLevel = 1'b0;
   // Whole pulses, each level held two or more cycles so none is missed
   task automatic pulses(input int n, input int w);
      for (int i = 0; i < n; i++) begin
         repeat (w < 2 ? 2 : w) @(posedge mclk);
         pinLevel <= 1'b1;
         repeat (w < 2 ? 2 : w) @(posedge mclk);
         pinLevel <= 1'b0;
      end
   endtask
endmodule

// *** dv/tmr0_overflow_counter_test.sv ***
// Self-checking bench for the timer block
`timescale 1ns/1ps
module tmr0_overflow_counter_test;
   import tmr0_pkg::*;
   logic mclk = 1'b0, reset = 1'b1, extCountPin;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, up;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, overflowIrq;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [7:0] irqVector, b, v1;
   int mismatches = 0, checked = 0, cyc = 0, n, t1, dv;
   tmr0_overflow_counter i_dut (.*);
   tmr0_pin_source i_src (.mclk(mclk), .pinLevel(extCountPin));
   always #10 mclk = ~mclk;
   always @(posedge mclk) cyc <= cyc + 1;
   // --------------------------------------------------------------
   // Bus tasks and expectations
   // --------------------------------------------------------------
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      up = $urandom;
      s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wstrb <= 4'hF;
      s_axi_wdata <= {up[23:0], v}; s_axi_wvalid <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) ||
                 (s_axi_wvalid && !s_axi_wready));
      s_axi_bready <= 1'b1;
      do @(posedge mclk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a);
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1;
      do @(posedge mclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0; s_axi_rready <= 1'b1;
      do @(posedge mclk); while (!s_axi_rvalid);
      d = s_axi_rdata; r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   function automatic logic [7:0] fullRead(input logic [4:0] a);
      case (a)
         5'h00: return 8'h07;
         5'h04: return 8'hFF;
         5'h08: return 8'h02;
         5'h10: return 8'h01;
         default: return 8'h00;
      endcase
   endfunction
   function automatic int divOf(input int code);
      case (code)
         1: return 1; 2: return 8; 3: return 64; 4: return 256; 5: return 1024;
         default: return 0;
      endcase
   endfunction
   task automatic summarize();
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Hang guard, well beyond the longest expected run
   initial begin
      #(20 * 90000);
      mismatches++;
      summarize();
   end
   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial begin
      void'($urandom(32'h17a08f3f));
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      for (int i = 0; i < 6; i++) begin
         rd(5'(i * 4));
         check(d, 0);
         check(r, i == 5 ? 2'b10 : 2'b00);
         wr(5'(i * 4), 8'hFF);
         check(r, i == 5 ? 2'b10 : 2'b00);
         rd(5'(i * 4));
         check(d[7:0], fullRead(5'(i * 4)));
      end
      wr(5'h00, 8'h00);
      b = 8'($urandom);
      wr(5'h04, b);
      rd(5'h04);
      check(d, {24'h0, b});
      $display("test registers done");
      // Rate of stop, clock and each divided source, measured over two timed reads
      for (int c = 0; c < 6; c++) begin
         dv = divOf(c);
         wr(5'h00, 8'(c));
         rd(5'h04); v1 = d[7:0]; t1 = cyc;
         repeat (20 * (dv == 0 ? 1 : dv)) @(posedge mclk);
         rd(5'h04);
         b = dv == 0 ? 8'h00 : 8'((cyc - t1) / dv);
         check(8'(d[7:0] - v1 - b + 8'h01) <= 8'h02, 1);
      end
      $display("test prescaler done");
      wr(5'h00, 8'h00); wr(5'h0C, 8'h02);
      check(overflowIrq, 0);
      wr(5'h04, 8'hF0); wr(5'h08, 8'h02); wr(5'h10, 8'h01);
      wr(5'h00, 8'h01);
      while (!overflowIrq) @(posedge mclk);
      check(irqVector, 8'h03);
      rd(5'h0C); check(d, 32'h2);
      wr(5'h0C, 8'h00); rd(5'h0C); check(d, 32'h2);
      wr(5'h08, 8'h00); @(posedge mclk);
      check(overflowIrq, 0);
      wr(5'h0C, 8'h02); rd(5'h0C); check(d, 32'h0);
      wr(5'h08, 8'h02);
      while (!overflowIrq) @(posedge mclk);
      wr(5'h10, 8'h03); rd(5'h0C); check(d, 32'h0);
      check(overflowIrq, 0);
      wr(5'h00, 8'h00);
      $display("test overflow done");
      // Pin driven by the source whatever its direction would be
      for (int c = 6; c < 8; c++) begin
         n = $urandom_range(1, 20);
         b = 8'($urandom);
         wr(5'h00, 8'(c));
         wr(5'h04, b);
         i_src.pulses(n, $urandom_range(2, 6));
         repeat (6) @(posedge mclk);
         rd(5'h04);
         check(d[7:0], 8'(b + n));
      end
      $display("test pin done");
      summarize();
   end
endmodule
